// ==== motax_defines.svh ====
// Notes on behaviour
// - motion events masked; error events never masked
// - bit 0 flags a normal stop
// - bit 1 flags buffered command start
// - bit 2 flags pre-register two empty
// - bits 8-12 flag comparators one to five
// - bit 13 flags counter clear input
// - bit 14 flags external latch capture
// - bit 15 flags home origin capture
// - bit 19 flags synchronous start activation
// - error interrupt unmaskable, cause as code
// - codes 0/1 soft limit stops
// - codes 2-4 comparator three to five stops
// - codes 5/6 hardware end-limit stops
// - code 7 servo alarm stop
// - code 8 sync stop or stop-all
// - code 9 emergency stop
// - code 10 slowdown decelerated stop
// - code 12 interpolation error, 15 overflow
// - code 13 stopped by other axis
// - code 14 pulse input buffer overflow
// - codes 16/17 signal errors, no stop
// - global axis is four times card plus index
// - comparator action: interrupt, stop, or slow
`ifndef MOTAX_DEFINES_SVH
`define MOTAX_DEFINES_SVH

// ----------------------------------------------------------------------
// motion event bit positions
// ----------------------------------------------------------------------
`define MOTAX_EV_W 32
`define MOTAX_EV_NORMAL_STOP 0
`define MOTAX_EV_BUF_START 1
`define MOTAX_EV_PREREG_EMPTY 2
`define MOTAX_EV_ACCEL_START 4
`define MOTAX_EV_ACCEL_END 5
`define MOTAX_EV_DECEL_START 6
`define MOTAX_EV_DECEL_END 7
`define MOTAX_EV_CMP_BASE 8
`define MOTAX_EV_COUNTER_CLEAR 13
`define MOTAX_EV_LATCH 14
`define MOTAX_EV_HOME_LATCH 15
`define MOTAX_EV_SLOWDOWN 16
`define MOTAX_EV_SYNC_START 19
`define MOTAX_EV_USED 32'h0009fff7
`define MOTAX_EV_RESET 32'h00000000

// ----------------------------------------------------------------------
// error codes
// ----------------------------------------------------------------------
`define MOTAX_ERR_W 5
`define MOTAX_ERR_N 18
`define MOTAX_ERR_SOFT_POS 0
`define MOTAX_ERR_SOFT_NEG 1
`define MOTAX_ERR_CMP3 2
`define MOTAX_ERR_CMP4 3
`define MOTAX_ERR_CMP5 4
`define MOTAX_ERR_END_POS 5
`define MOTAX_ERR_END_NEG 6
`define MOTAX_ERR_ALARM 7
`define MOTAX_ERR_SYNC_STOP 8
`define MOTAX_ERR_EMERGENCY 9
`define MOTAX_ERR_SLOWDOWN 10
`define MOTAX_ERR_INTERP 12
`define MOTAX_ERR_OTHER_AXIS 13
`define MOTAX_ERR_PULSE_BUF 14
`define MOTAX_ERR_INTERP_OVF 15
`define MOTAX_ERR_ENCODER 16
`define MOTAX_ERR_PULSE_SIG 17
`define MOTAX_ERR_RESET 5'h00

// ----------------------------------------------------------------------
// comparators and axis numbering
// ----------------------------------------------------------------------
`define MOTAX_NUM_CMP 5
`define MOTAX_AXES_PER_CARD 4
`define MOTAX_AXIS_IDX_W 2

`endif

// ==== motax_pkg.sv ====
`default_nettype none

package motax_pkg;

  // comparator action on a match
  typedef enum logic [1:0] {
    MOTAX_ACT_NONE = 2'h0,
    MOTAX_ACT_IRQ = 2'h1,
    MOTAX_ACT_STOP = 2'h2,
    MOTAX_ACT_SLOW = 2'h3
  } motax_action_t;

  // ramp phase, gray coded along idle, accel, cruise, decel
  typedef enum logic [1:0] {
    MOTAX_RAMP_IDLE = 2'h0,
    MOTAX_RAMP_ACCEL = 2'h1,
    MOTAX_RAMP_CRUISE = 2'h3,
    MOTAX_RAMP_DECEL = 2'h2
  } motax_ramp_t;

endpackage : motax_pkg

`default_nettype wire

// ==== motax_event_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motax_defines.svh"

module motax_event_latch #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] USED = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic [WIDTH-1:0] mask_bits,
  output logic [WIDTH-1:0] status_q,
  output logic irq_q
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("motax_event_latch: width must be at least 1");
    end
  endgenerate

  wire [WIDTH-1:0] status_d;
  wire [WIDTH-1:0] pending = status_d & mask_bits;

  // ----------------------------------------------------------------------
  // sticky bits, set wins over a same-cycle clear
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // unused positions are tied off so they never latch
      assign status_d[i] = USED[i] & (set_bits[i] | (status_q[i] & ~clear_bits[i]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |pending;
    end
  end

endmodule : motax_event_latch
`default_nettype wire

// ==== motax_err_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motax_defines.svh"

module motax_err_encoder #(
  parameter int N = `MOTAX_ERR_N,
  parameter int CODE_W = `MOTAX_ERR_W
) (
  input wire logic [N-1:0] cause,
  output logic valid,
  output logic [CODE_W-1:0] code
);

  generate
    if (N > (1 << CODE_W)) begin : g_bad
      $error("motax_err_encoder: code width too small for cause count");
    end
  endgenerate

  // lowest code wins when causes coincide
  function automatic logic [CODE_W-1:0] first_set(input logic [N-1:0] v);
    logic [CODE_W-1:0] r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = CODE_W'(k);
      end
    end
    return r;
  endfunction : first_set

  assign valid = |cause;
  assign code = first_set(cause);

endmodule : motax_err_encoder
`default_nettype wire

// ==== motax_axis_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motax_defines.svh"

module motax_axis_irq #(
  parameter int CARD_ID_W = 4,
  parameter int AXIS_INDEX = 0
) (
  input wire logic clk,
  input wire logic resetn,
  // pins from the connector, asynchronous
  input wire logic counter_clear_input,
  input wire logic latch_input,
  input wire logic home_origin_input,
  input wire logic slowdown_input,
  input wire logic sync_start_input,
  input wire logic sync_stop_input,
  input wire logic emergency_stop_input,
  input wire logic end_limit_pos_input,
  input wire logic end_limit_neg_input,
  input wire logic servo_alarm_input,
  input wire logic [CARD_ID_W-1:0] card_id_switch,
  // pulses from the motion core, same clock
  input wire logic normal_stop_evt,
  input wire logic buf_cmd_start_evt,
  input wire logic prereg_empty_evt,
  input wire logic [`MOTAX_NUM_CMP-1:0] cmp_match_evt,
  input wire logic start_all_cmd,
  input wire logic stop_all_cmd,
  input wire logic interp_error_evt,
  input wire logic other_axis_stop_evt,
  input wire logic pulse_buf_ovf_evt,
  input wire logic interp_ovf_evt,
  input wire logic encoder_sig_error_evt,
  input wire logic pulse_sig_error_evt,
  // ramp phase levels from the pulse generator
  input wire logic axis_moving,
  input wire logic accel_active,
  input wire logic decel_active,
  // host side control
  input wire logic [`MOTAX_EV_W-1:0] motion_mask,
  input wire logic [`MOTAX_EV_W-1:0] motion_clear,
  input wire logic error_clear,
  input wire logic [2*`MOTAX_NUM_CMP-1:0] cmp_action,
  input wire logic slowdown_stop_en,
  // status and interrupts
  output logic [`MOTAX_EV_W-1:0] motion_status_q,
  output logic motion_irq_q,
  output logic error_irq_q,
  output logic [`MOTAX_ERR_W-1:0] error_code_q,
  output logic stop_now_q,
  output logic slow_stop_q,
  output logic [CARD_ID_W+`MOTAX_AXIS_IDX_W-1:0] global_axis_q
);

  generate
    if (AXIS_INDEX < 0 || AXIS_INDEX >= `MOTAX_AXES_PER_CARD) begin : g_bad_axis
      $error("motax_axis_irq: axis index must be 0 to 3");
    end
    if (CARD_ID_W < 1 || CARD_ID_W > 8) begin : g_bad_id
      $error("motax_axis_irq: card id width must be 1 to 8");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // pin synchronisers and rising edge detect
  // ----------------------------------------------------------------------
  localparam int NPIN = 10;
  localparam int P_CCLEAR = 0;
  localparam int P_LTC = 1;
  localparam int P_HOME = 2;
  localparam int P_SLOW = 3;
  localparam int P_START = 4;
  localparam int P_STOP = 5;
  localparam int P_EMG = 6;
  localparam int P_ELP = 7;
  localparam int P_ELN = 8;
  localparam int P_ALM = 9;

  wire [NPIN-1:0] pin_raw = {servo_alarm_input, end_limit_neg_input, end_limit_pos_input,
                             emergency_stop_input, sync_stop_input, sync_start_input,
                             slowdown_input, home_origin_input, latch_input,
                             counter_clear_input};

  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_sync_q;
  logic [NPIN-1:0] pin_last_q;
  logic [CARD_ID_W-1:0] id_meta_q;
  logic [CARD_ID_W-1:0] id_sync_q;

  // only the second stage and the edge-detect copy after it feed logic; the first is never looked at
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_last_q <= '0;
      id_meta_q <= '0;
      id_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
      id_meta_q <= card_id_switch;
      id_sync_q <= id_meta_q;
    end
  end

  wire [NPIN-1:0] pin_rise = pin_sync_q & ~pin_last_q;

  // ----------------------------------------------------------------------
  // ramp phase tracker
  // ----------------------------------------------------------------------
  motax_pkg::motax_ramp_t ramp_q;
  motax_pkg::motax_ramp_t ramp_d;

  always_comb begin
    ramp_d = ramp_q;
    case (ramp_q)
      motax_pkg::MOTAX_RAMP_IDLE: begin
        if (decel_active) begin
          ramp_d = motax_pkg::MOTAX_RAMP_DECEL;
        end else if (accel_active) begin
          ramp_d = motax_pkg::MOTAX_RAMP_ACCEL;
        end
      end
      motax_pkg::MOTAX_RAMP_ACCEL: begin
        if (decel_active) begin
          ramp_d = motax_pkg::MOTAX_RAMP_DECEL;
        end else if (!accel_active) begin
          ramp_d = axis_moving ? motax_pkg::MOTAX_RAMP_CRUISE : motax_pkg::MOTAX_RAMP_IDLE;
        end
      end
      motax_pkg::MOTAX_RAMP_CRUISE: begin
        if (decel_active) begin
          ramp_d = motax_pkg::MOTAX_RAMP_DECEL;
        end else if (accel_active) begin
          ramp_d = motax_pkg::MOTAX_RAMP_ACCEL;
        end else if (!axis_moving) begin
          ramp_d = motax_pkg::MOTAX_RAMP_IDLE;
        end
      end
      motax_pkg::MOTAX_RAMP_DECEL: begin
        if (!decel_active) begin
          if (accel_active) begin
            ramp_d = motax_pkg::MOTAX_RAMP_ACCEL;
          end else begin
            ramp_d = axis_moving ? motax_pkg::MOTAX_RAMP_CRUISE : motax_pkg::MOTAX_RAMP_IDLE;
          end
        end
      end
      default: begin
        ramp_d = motax_pkg::MOTAX_RAMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ramp_q <= motax_pkg::MOTAX_RAMP_IDLE;
    end else begin
      ramp_q <= ramp_d;
    end
  end

  // one pulse per phase edge, never repeated while the phase holds
  wire in_accel = (ramp_q == motax_pkg::MOTAX_RAMP_ACCEL);
  wire to_accel = (ramp_d == motax_pkg::MOTAX_RAMP_ACCEL);
  wire in_decel = (ramp_q == motax_pkg::MOTAX_RAMP_DECEL);
  wire to_decel = (ramp_d == motax_pkg::MOTAX_RAMP_DECEL);
  wire accel_start = to_accel & ~in_accel;
  wire accel_end = in_accel & ~to_accel;
  wire decel_start = to_decel & ~in_decel;
  wire decel_end = in_decel & ~to_decel;

  // ----------------------------------------------------------------------
  // comparator action decode
  // ----------------------------------------------------------------------
  function automatic motax_pkg::motax_action_t action_of(input int idx);
    return motax_pkg::motax_action_t'(cmp_action[2*idx +: 2]);
  endfunction : action_of

  wire [`MOTAX_NUM_CMP-1:0] cmp_irq;
  wire [`MOTAX_NUM_CMP-1:0] cmp_stop;
  wire [`MOTAX_NUM_CMP-1:0] cmp_slow;

  genvar c;
  generate
    for (c = 0; c < `MOTAX_NUM_CMP; c++) begin : g_cmp
      assign cmp_irq[c] = cmp_match_evt[c] & (action_of(c) == motax_pkg::MOTAX_ACT_IRQ);
      assign cmp_stop[c] = cmp_match_evt[c] & (action_of(c) == motax_pkg::MOTAX_ACT_STOP);
      assign cmp_slow[c] = cmp_match_evt[c] & (action_of(c) == motax_pkg::MOTAX_ACT_SLOW);
    end
  endgenerate

  wire [`MOTAX_NUM_CMP-1:0] cmp_halt = cmp_stop | cmp_slow;

  // ----------------------------------------------------------------------
  // motion event vector
  // ----------------------------------------------------------------------
  logic [`MOTAX_EV_W-1:0] motion_set;

  always_comb begin
    motion_set = '0;
    motion_set[`MOTAX_EV_NORMAL_STOP] = normal_stop_evt;
    motion_set[`MOTAX_EV_BUF_START] = buf_cmd_start_evt;
    motion_set[`MOTAX_EV_PREREG_EMPTY] = prereg_empty_evt;
    motion_set[`MOTAX_EV_ACCEL_START] = accel_start;
    motion_set[`MOTAX_EV_ACCEL_END] = accel_end;
    motion_set[`MOTAX_EV_DECEL_START] = decel_start;
    motion_set[`MOTAX_EV_DECEL_END] = decel_end;
    motion_set[`MOTAX_EV_CMP_BASE +: `MOTAX_NUM_CMP] = cmp_irq;
    motion_set[`MOTAX_EV_COUNTER_CLEAR] = pin_rise[P_CCLEAR];
    motion_set[`MOTAX_EV_LATCH] = pin_rise[P_LTC];
    motion_set[`MOTAX_EV_HOME_LATCH] = pin_rise[P_HOME];
    motion_set[`MOTAX_EV_SLOWDOWN] = pin_rise[P_SLOW];
    motion_set[`MOTAX_EV_SYNC_START] = pin_rise[P_START] | start_all_cmd;
  end

  motax_event_latch #(
    .WIDTH(`MOTAX_EV_W),
    .USED(`MOTAX_EV_USED)
  ) u_motion (
    .clk(clk),
    .resetn(resetn),
    .set_bits(motion_set),
    .clear_bits(motion_clear),
    .mask_bits(motion_mask),
    .status_q(motion_status_q),
    .irq_q(motion_irq_q)
  );

  // ----------------------------------------------------------------------
  // error causes, no mask anywhere on this path
  // ----------------------------------------------------------------------
  logic [`MOTAX_ERR_N-1:0] err_cause;
  wire slow_err = pin_rise[P_SLOW] & slowdown_stop_en;

  always_comb begin
    err_cause = '0;
    err_cause[`MOTAX_ERR_SOFT_POS] = cmp_halt[0];
    err_cause[`MOTAX_ERR_SOFT_NEG] = cmp_halt[1];
    err_cause[`MOTAX_ERR_CMP3] = cmp_halt[2];
    err_cause[`MOTAX_ERR_CMP4] = cmp_halt[3];
    err_cause[`MOTAX_ERR_CMP5] = cmp_halt[4];
    err_cause[`MOTAX_ERR_END_POS] = pin_rise[P_ELP];
    err_cause[`MOTAX_ERR_END_NEG] = pin_rise[P_ELN];
    err_cause[`MOTAX_ERR_ALARM] = pin_rise[P_ALM];
    err_cause[`MOTAX_ERR_SYNC_STOP] = pin_rise[P_STOP] | stop_all_cmd;
    err_cause[`MOTAX_ERR_EMERGENCY] = pin_rise[P_EMG];
    err_cause[`MOTAX_ERR_SLOWDOWN] = slow_err;
    err_cause[`MOTAX_ERR_INTERP] = interp_error_evt;
    err_cause[`MOTAX_ERR_OTHER_AXIS] = other_axis_stop_evt;
    err_cause[`MOTAX_ERR_PULSE_BUF] = pulse_buf_ovf_evt;
    err_cause[`MOTAX_ERR_INTERP_OVF] = interp_ovf_evt;
    err_cause[`MOTAX_ERR_ENCODER] = encoder_sig_error_evt;
    err_cause[`MOTAX_ERR_PULSE_SIG] = pulse_sig_error_evt;
  end

  wire err_valid;
  wire [`MOTAX_ERR_W-1:0] err_code;

  motax_err_encoder #(
    .N(`MOTAX_ERR_N),
    .CODE_W(`MOTAX_ERR_W)
  ) u_enc (
    .cause(err_cause),
    .valid(err_valid),
    .code(err_code)
  );

  // codes 15 to 17 report without halting the axis
  wire hard_stop = |cmp_stop | pin_rise[P_ELP] | pin_rise[P_ELN] | pin_rise[P_ALM]
                 | err_cause[`MOTAX_ERR_SYNC_STOP] | pin_rise[P_EMG]
                 | interp_error_evt | other_axis_stop_evt | pulse_buf_ovf_evt;
  wire soft_stop = |cmp_slow | slow_err;

  // first error is kept until the host clears; a new one in the clear cycle wins
  wire err_take = err_valid & (~error_irq_q | error_clear);
  wire err_pend_d = err_valid | (error_irq_q & ~error_clear);
  wire [`MOTAX_ERR_W-1:0] err_code_d = err_take ? err_code : error_code_q;

  // ----------------------------------------------------------------------
  // global axis number
  // ----------------------------------------------------------------------
  localparam logic [`MOTAX_AXIS_IDX_W-1:0] AXIS_IDX = `MOTAX_AXIS_IDX_W'(AXIS_INDEX);
  wire [CARD_ID_W+`MOTAX_AXIS_IDX_W-1:0] axis_num = {id_sync_q, AXIS_IDX};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_irq_q <= 1'b0;
      error_code_q <= `MOTAX_ERR_RESET;
      stop_now_q <= 1'b0;
      slow_stop_q <= 1'b0;
      global_axis_q <= '0;
    end else begin
      error_irq_q <= err_pend_d;
      error_code_q <= err_code_d;
      stop_now_q <= hard_stop;
      slow_stop_q <= soft_stop & ~hard_stop;
      global_axis_q <= axis_num;
    end
  end

endmodule : motax_axis_irq
`default_nettype wire

// ==== motax_err_encoder_unused_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== motax_axis_irq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motax_defines.svh"

module motax_axis_irq_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic normal_stop_evt,
  input wire logic pulse_buf_ovf_evt,
  input wire logic error_clear,
  input wire logic [`MOTAX_EV_W-1:0] motion_mask,
  input wire logic [`MOTAX_EV_W-1:0] motion_clear,
  input wire logic [`MOTAX_EV_W-1:0] motion_status_q,
  input wire logic motion_irq_q,
  input wire logic error_irq_q,
  input wire logic [`MOTAX_ERR_W-1:0] error_code_q,
  input wire logic stop_now_q,
  input wire logic slow_stop_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // motion events
  // ----------------------------------------------------------------
  chk_unused_zero: assert property ((motion_status_q & ~`MOTAX_EV_USED) == '0)
    else $error("unused motion bit set");
  chk_irq_mask: assert property (motion_irq_q == |(motion_status_q & $past(motion_mask)))
    else $error("motion irq disagrees with masked status");
  chk_stop_set: assert property (normal_stop_evt |=> motion_status_q[0])
    else $error("normal stop not latched");
  chk_stop_sticky: assert property (motion_status_q[0] && !motion_clear[0] |=> motion_status_q[0])
    else $error("normal stop status lost");
  chk_stop_clear: assert property (!normal_stop_evt && motion_clear[0] |=> !motion_status_q[0])
    else $error("normal stop status not cleared");

  // ----------------------------------------------------------------
  // error events
  // ----------------------------------------------------------------
  sequence ovf_taken;
    !error_irq_q && pulse_buf_ovf_evt;
  endsequence
  sequence err_answer;
    error_irq_q && stop_now_q && error_code_q <= 5'he;
  endsequence
  chk_ovf_stop: assert property (ovf_taken |=> err_answer)
    else $error("buffer overflow gave no error stop");
  chk_code_hold: assert property (error_irq_q && !error_clear |=> error_irq_q && $stable(error_code_q))
    else $error("pending error changed");
  chk_stop_kind: assert property ($rose(error_irq_q) |-> (stop_now_q || slow_stop_q) == (error_code_q < 5'hf))
    else $error("stop request disagrees with error code");
  chk_stop_excl: assert property (!(stop_now_q && slow_stop_q))
    else $error("stop and slow stop together");
endmodule : motax_axis_irq_chk

bind motax_axis_irq motax_axis_irq_chk motax_axis_irq_chk_i (
  .clk(clk), .resetn(resetn), .normal_stop_evt(normal_stop_evt),
  .pulse_buf_ovf_evt(pulse_buf_ovf_evt), .error_clear(error_clear), .motion_mask(motion_mask),
  .motion_clear(motion_clear), .motion_status_q(motion_status_q), .motion_irq_q(motion_irq_q),
  .error_irq_q(error_irq_q), .error_code_q(error_code_q), .stop_now_q(stop_now_q),
  .slow_stop_q(slow_stop_q)
);

`default_nettype wire

// ==== motax_axis_irq_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motax_defines.svh"

module motax_axis_irq_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] pin = '0;
  logic [15:0] pls = '0;
  logic [2:0] ramp = '0;
  logic [31:0] mask = '0;
  logic [31:0] wclear = '0;
  logic eclear = 1'b0;
  logic [9:0] act = '0;
  logic slow_en = 1'b0;
  logic [3:0] card = 4'h3;
  logic [31:0] status;
  logic mirq, eirq, stop_q, slow_q;
  logic [4:0] ecode;
  logic [5:0] gax;
  int n_mismatch = 0;
  int n_checks = 0;

  motax_axis_irq #(.CARD_ID_W(4), .AXIS_INDEX(2)) motax_axis_irq_i (
    .clk(clk), .resetn(resetn), .counter_clear_input(pin[0]), .latch_input(pin[1]),
    .home_origin_input(pin[2]), .slowdown_input(pin[3]), .sync_start_input(pin[4]),
    .sync_stop_input(pin[5]), .emergency_stop_input(pin[6]), .end_limit_pos_input(pin[7]),
    .end_limit_neg_input(pin[8]), .servo_alarm_input(pin[9]), .card_id_switch(card),
    .normal_stop_evt(pls[0]), .buf_cmd_start_evt(pls[1]), .prereg_empty_evt(pls[2]),
    .cmp_match_evt(pls[7:3]), .start_all_cmd(pls[8]), .stop_all_cmd(pls[9]),
    .interp_error_evt(pls[10]), .other_axis_stop_evt(pls[11]), .pulse_buf_ovf_evt(pls[12]),
    .interp_ovf_evt(pls[13]), .encoder_sig_error_evt(pls[14]), .pulse_sig_error_evt(pls[15]),
    .axis_moving(ramp[2]), .accel_active(ramp[1]), .decel_active(ramp[0]),
    .motion_mask(mask), .motion_clear(wclear), .error_clear(eclear), .cmp_action(act),
    .slowdown_stop_en(slow_en), .motion_status_q(status), .motion_irq_q(mirq),
    .error_irq_q(eirq), .error_code_q(ecode), .stop_now_q(stop_q), .slow_stop_q(slow_q),
    .global_axis_q(gax)
  );

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // sources 0..9 are pins, 10..25 are same-clock pulses
  task automatic fire(input int s);
    if (s < 10) begin
      pin[s] = 1'b1;
    end else begin
      pls[s-10] = 1'b1;
    end
    tick;
    pin = '0;
    pls = '0;
  endtask : fire

  // pins need a few edges through the synchroniser, so wait bounded
  task automatic settle(input logic err, output logic st, output logic sl);
    st = 1'b0;
    sl = 1'b0;
    for (int i = 0; i < 8; i++) begin
      st |= stop_q;
      sl |= slow_q;
      if (err ? eirq === 1'b1 : status != '0) break;
      tick;
    end
  endtask : settle

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ident;
    check(gax, 6'h0e);
    card = 4'h5;
    repeat (4) tick;
    check(gax, 6'h16);
  endtask : t_ident

  task automatic t_motion;
    int src[14] = '{0, 1, 2, 3, 4, 10, 11, 12, 13, 14, 15, 16, 17, 18};
    int bn[14] = '{13, 14, 15, 16, 19, 0, 1, 2, 8, 9, 10, 11, 12, 19};
    logic st, sl;
    act = 10'h155;
    for (int k = 0; k < 14; k++) begin
      mask = k[0] ? ~(32'h1 << bn[k]) : 32'hffff_ffff;
      fire(src[k]);
      settle(1'b0, st, sl);
      check(status, 32'h1 << bn[k]);
      check(mirq, !k[0]);
      check(eirq, 1'b0);
      wclear = 32'hffff_ffff;
      tick;
      wclear = '0;
      check(status, 32'h0);
    end
  endtask : t_motion

  task automatic t_ramp;
    logic [2:0] lv[4] = '{3'h6, 3'h4, 3'h5, 3'h4};
    for (int k = 0; k < 4; k++) begin
      ramp = lv[k];
      tick;
      check(status, 32'h10 << k);
      wclear = 32'hf0;
      tick;
      wclear = '0;
      tick;
      check(status, 32'h0);
    end
    ramp = '0;
  endtask : t_ramp

  task automatic t_errors;
    int src[19] = '{13, 14, 15, 16, 17, 15, 5, 6, 7, 8, 9, 3, 19, 20, 21, 22, 23, 24, 25};
    int code[19] = '{0, 1, 2, 3, 4, 2, 8, 9, 5, 6, 7, 10, 8, 12, 13, 14, 15, 16, 17};
    logic st, sl, slow;
    mask = '0;
    slow_en = 1'b1;
    for (int k = 0; k < 19; k++) begin
      slow = (k == 5 || k == 11);
      act = (k == 5) ? 10'h3ff : 10'h2aa;
      fire(src[k]);
      settle(1'b1, st, sl);
      check(eirq, 1'b1);
      check(ecode, code[k]);
      check({st, sl}, {!slow && code[k] < 15, slow});
      eclear = 1'b1;
      wclear = 32'hffff_ffff;
      tick;
      eclear = 1'b0;
      wclear = '0;
      check(eirq, 1'b0);
    end
    slow_en = 1'b0;
  endtask : t_errors

  task automatic t_order;
    logic st, sl;
    pls[10] = 1'b1;
    fire(21);
    settle(1'b1, st, sl);
    check(ecode, 5'hc);
    fire(6);
    repeat (6) tick;
    check({eirq, ecode}, {1'b1, 5'hc});
    eclear = 1'b1;
    fire(22);
    eclear = 1'b0;
    check({eirq, ecode}, {1'b1, 5'he});
    eclear = 1'b1;
    tick;
    eclear = 1'b0;
    act = '0;
    fire(13);
    repeat (3) tick;
    check({status[8], eirq}, 2'h0);
    wclear = 32'h1;
    fire(10);
    wclear = '0;
    check(status, 32'h1);
    repeat (2) tick;
    check(status, 32'h1);
  endtask : t_order

  initial begin
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) tick;
    t_ident;
    t_motion;
    t_ramp;
    t_errors;
    t_order;
    final_report;
  end

  // whole run is under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
endmodule : motax_axis_irq_test

`default_nettype wire
